/* File: core/cfm_pkg.sv */
package cfm_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned STEP_MS       = 10;
    localparam int unsigned STEP_CYCLES   = (CLK_HZ / 1000) * STEP_MS;

    // Feedback time setting, in milliseconds and in steps
    localparam int unsigned FB_MIN_MS     = 100;
    localparam int unsigned FB_MAX_MS     = 1000;
    localparam int unsigned FB_DEFAULT_MS = 300;
    localparam int unsigned TMR_W         = 7;
    localparam logic [TMR_W-1:0] FB_MIN_STEPS = TMR_W'(FB_MIN_MS / STEP_MS);
    localparam logic [TMR_W-1:0] FB_MAX_STEPS = TMR_W'(FB_MAX_MS / STEP_MS);
    localparam logic [TMR_W-1:0] FB_DEF_STEPS = TMR_W'(FB_DEFAULT_MS / STEP_MS);

    // Register byte offsets
    localparam int unsigned ADDR_W        = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SETTING = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_TIMER   = 4'hC;

    // Control fields
    localparam int unsigned CTRL_W        = 4;
    typedef struct packed {
        logic fault_en;
        logic err_en;
        logic out2_en;
        logic run;
    } cfm_ctrl_t;
    localparam cfm_ctrl_t CTRL_RESET = '{fault_en: 1'b1, err_en: 1'b1, out2_en: 1'b1, run: 1'b1};

    // Status fields
    localparam int unsigned STAT_W        = 6;
    typedef struct packed {
        logic pending;
        logic err;
        logic out2;
        logic out1;
        logic fb;
        logic mon;
    } cfm_stat_t;

    // Register access carried from the bus slave
    typedef struct packed {
        logic        en;
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } cfm_wr_t;

    // Feedback level expected while outputs are OFF; ON is its complement
    localparam logic FB_WHEN_OFF = 1'b1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: core/cfm_axil.sv */
`timescale 1ns/1ps
module cfm_axil
    import cfm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output cfm_wr_t                wr,
    input  wire logic              wr_ok,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_ok
);

    logic              aw_held, next_aw_held, w_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0]       w_data, next_w_data;
    logic [3:0]        w_strb, next_w_strb;
    logic              next_bvalid, next_rvalid;
    logic [1:0]        next_bresp, next_rresp;
    logic [31:0]       next_rdata;
    logic              next_awready, next_wready, next_arready;

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes from the held address and data, reads from the live read address
    assign rd_addr = s_axi_araddr;
    assign wr      = '{en: aw_held & w_held, addr: aw_addr, data: w_data, strb: w_strb};

    // Address and data taken in either order, response after both
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr.en) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_data;
            next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // Readiness registered so every channel ready comes from a flop
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready  = ~next_w_held & ~next_bvalid;
        next_arready = ~next_rvalid;
    end

    // Channel state registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= '0;
            w_held       <= 1'b0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            aw_held      <= next_aw_held;
            aw_addr      <= next_aw_addr;
            w_held       <= next_w_held;
            w_data       <= next_w_data;
            w_strb       <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp  <= next_rresp;
            s_axi_rdata  <= next_rdata;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_arready <= next_arready;
        end
    end

endmodule // cfm_axil

/* File: core/cfm_top.sv */
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module cfm_top
    import cfm_pkg::*;
#(
    parameter int unsigned CYCLE_CLKS = STEP_CYCLES
)(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              monitored_in,
    input  wire logic              contactor_feedback_in,
    output logic                   safety_out1,
    output logic                   safety_out2,
    output logic                   feedback_timeout_error,
    output logic                   fault_present,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    localparam int unsigned DIV_W = $clog2(CYCLE_CLKS + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLE_CLKS - 1);

    cfm_wr_t            wr;
    logic               wr_ok;
    logic [ADDR_W-1:0]  rd_addr;
    logic [31:0]        rd_data;
    logic               rd_ok;

    cfm_ctrl_t          ctrl, next_ctrl;
    logic [TMR_W-1:0]   setting, next_setting;
    logic [TMR_W-1:0]   wr_setting;
    logic [DIV_W-1:0]   div, next_div;
    logic               tick;
    logic               start, next_start;
    logic               mon_prev, next_mon_prev;
    logic               out, next_out;
    logic               err, next_err;
    logic               pending, next_pending;
    logic [TMR_W-1:0]   timer, next_timer;
    logic               next_out1, next_out2, next_err_out, next_fault;
    cfm_stat_t          stat;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave
    cfm_axil u_axil (
        .clk           (clk),
        .resetn        (resetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr            (wr),
        .wr_ok         (wr_ok),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode and readback
    assign wr_ok = (wr.addr == OFS_CTRL) || (wr.addr == OFS_SETTING)
                || (wr.addr == OFS_STATUS) || (wr.addr == OFS_TIMER);
    assign rd_ok = (rd_addr == OFS_CTRL) || (rd_addr == OFS_SETTING)
                || (rd_addr == OFS_STATUS) || (rd_addr == OFS_TIMER);
    assign stat  = '{pending: pending, err: err, out2: safety_out2, out1: safety_out1,
                     fb: contactor_feedback_in, mon: monitored_in};

    // Read multiplexer, unused bits read as zero
    always_comb begin
        rd_data = '0;
        case (rd_addr)
            OFS_CTRL:    rd_data = {{(32-CTRL_W){1'b0}}, ctrl};
            OFS_SETTING: rd_data = {{(32-TMR_W){1'b0}}, setting};
            OFS_STATUS:  rd_data = {{(32-STAT_W){1'b0}}, stat};
            OFS_TIMER:   rd_data = {{(32-TMR_W){1'b0}}, timer};
            default:     rd_data = '0;
        endcase
    end

    // Setting written in 10 ms steps, clamped into the legal range
    always_comb begin
        wr_setting = wr.data[TMR_W-1:0];
        if (wr.data[31:TMR_W] != '0 || wr_setting > FB_MAX_STEPS) begin
            wr_setting = FB_MAX_STEPS;
        end else if (wr_setting < FB_MIN_STEPS) begin
            wr_setting = FB_MIN_STEPS;
        end
    end

    // Control and setting writes, low byte lane carries every field
    always_comb begin
        next_ctrl    = ctrl;
        next_setting = setting;
        if (wr.en && wr.strb[0]) begin
            if (wr.addr == OFS_CTRL) begin
                next_ctrl = cfm_ctrl_t'(wr.data[CTRL_W-1:0]);
            end
            if (wr.addr == OFS_SETTING) begin
                next_setting = wr_setting;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl    <= CTRL_RESET;
            setting <= FB_DEF_STEPS;
        end else begin
            ctrl    <= next_ctrl;
            setting <= next_setting;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Controller cycle divider, one tick per 10 ms step
    always_comb begin
        tick     = (div == DIV_LAST);
        next_div = tick ? '0 : div + DIV_W'(1);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div <= '0;
        end else begin
            div <= next_div;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Contactor check, evaluated once per controller cycle
    always_comb begin
        next_start    = start;
        next_mon_prev = mon_prev;
        next_out      = out;
        next_err      = err;
        next_pending  = pending;
        next_timer    = timer;
        if (!ctrl.run) begin
            // Idle mode: outputs safe, next run entry is a start of operation
            next_start   = 1'b1;
            next_out     = 1'b0;
            next_pending = 1'b0;
        end else if (tick) begin
            next_mon_prev = monitored_in;
            if (start) begin
                next_start   = 1'b0;
                next_err     = 1'b0;
                next_timer   = '0;
                next_pending = 1'b0;
                next_out     = monitored_in;
            end else if (err) begin
                next_out = 1'b0;
                if (monitored_in && !mon_prev
                    && contactor_feedback_in == FB_WHEN_OFF) begin
                    next_err     = 1'b0;
                    next_out     = 1'b1;
                    next_pending = 1'b1;
                    next_timer   = '0;
                end
            end else if (monitored_in != out) begin
                next_out     = monitored_in;
                next_pending = 1'b1;
                next_timer   = '0;
            end else if (pending) begin
                if (contactor_feedback_in == (out ? ~FB_WHEN_OFF : FB_WHEN_OFF)) begin
                    next_pending = 1'b0;
                end else if (timer + TMR_W'(1) >= setting) begin
                    next_timer   = timer + TMR_W'(1);
                    next_err     = 1'b1;
                    next_out     = 1'b0;
                    next_pending = 1'b0;
                end else begin
                    next_timer = timer + TMR_W'(1);
                end
            end
        end
    end

    // Pin outputs registered, optional ones gated by their enables
    always_comb begin
        next_out1    = next_out;
        next_out2    = ctrl.out2_en & next_out;
        next_err_out = ctrl.err_en & next_err;
        next_fault   = ctrl.fault_en & next_err;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start                  <= 1'b1;
            mon_prev               <= 1'b0;
            out                    <= 1'b0;
            err                    <= 1'b0;
            pending                <= 1'b0;
            timer                  <= '0;
            safety_out1            <= 1'b0;
            safety_out2            <= 1'b0;
            feedback_timeout_error <= 1'b0;
            fault_present          <= 1'b0;
        end else begin
            start                  <= next_start;
            mon_prev               <= next_mon_prev;
            out                    <= next_out;
            err                    <= next_err;
            pending                <= next_pending;
            timer                  <= next_timer;
            safety_out1            <= next_out1;
            safety_out2            <= next_out2;
            feedback_timeout_error <= next_err_out;
            fault_present          <= next_fault;
        end
    end

endmodule // cfm_top

/* File: test/cfm_top_properties.sv */
`timescale 1ns/1ps
module cfm_top_properties
    import cfm_pkg::*;
#(
    parameter int unsigned CYCLE_CLKS = 4
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic monitored_in,
    input wire logic contactor_feedback_in,
    input wire logic safety_out1,
    input wire logic safety_out2,
    input wire logic feedback_timeout_error,
    input wire logic fault_present,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // One tick period plus the clock that shows the result
    localparam int TICK_WIN = CYCLE_CLKS + 1;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Output relations
    chk_out2_copy: assert property (safety_out2 |-> safety_out1)
        else $error("Second output on while first is off");
    chk_rise_cause: assert property ($rose(safety_out1) |-> $past(monitored_in))
        else $error("Output turned on without the input");
    chk_fall_follow: assert property
        (safety_out1 && !monitored_in |-> ##[0:TICK_WIN] (!safety_out1 || monitored_in))
        else $error("Output stayed on after input off");
    chk_err_off: assert property (feedback_timeout_error |-> !safety_out1 && !safety_out2)
        else $error("Output on while error shown");
    chk_fault_off: assert property (fault_present |-> !safety_out1)
        else $error("Output on while fault shown");
    chk_err_cause: assert property
        ($rose(feedback_timeout_error) && $rose(fault_present)
         |-> $past(contactor_feedback_in) == $past(safety_out1))
        else $error("Error latched while feedback was correct");

    // Register bus handshakes
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late");
    chk_write_lat: assert property
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write answer late");
    chk_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write taken during response");
    chk_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read taken during response");

    cover property ($rose(feedback_timeout_error));
    cover property ($fell(fault_present) && safety_out1);
    cover property ($rose(safety_out1) && safety_out2);
endmodule // cfm_top_properties

bind cfm_top cfm_top_properties #(.CYCLE_CLKS(CYCLE_CLKS)) u_cfm_top_properties (
    .clk, .resetn, .monitored_in, .contactor_feedback_in, .safety_out1, .safety_out2,
    .feedback_timeout_error, .fault_present, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid
);

/* File: test/cfm_contactor.sv */
`timescale 1ns/1ps
module cfm_contactor (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       coil,
    input  wire logic       welded,
    input  wire logic [7:0] delay_clks,
    output logic            feedback
);
    logic       closed;
    logic       next_closed;
    logic [7:0] cnt;
    logic [7:0] next_cnt;

    // Armature follows the coil after its travel time; a weld freezes it
    always_comb begin
        next_closed = closed;
        next_cnt    = 8'h00;
        if (!welded && coil != closed) begin
            next_cnt = cnt + 8'h01;
            if (cnt >= delay_clks) begin
                next_closed = coil;
                next_cnt    = 8'h00;
            end
        end
    end

    // Armature state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            closed <= 1'b0;
            cnt    <= 8'h00;
        end else begin
            closed <= next_closed;
            cnt    <= next_cnt;
        end
    end

    // Feedback contact is closed while the armature is open
    assign feedback = ~closed;
endmodule // cfm_contactor

/* File: test/cfm_top_test.sv */
`timescale 1ns/1ps
`define CHECK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module cfm_top_test
    import cfm_pkg::*;
;
    localparam int unsigned CYC = 4;
    logic              clk = 1'b0;
    logic              resetn, monitored_in, fb, welded;
    logic [7:0]        delay_clks;
    logic              safety_out1, safety_out2, feedback_timeout_error, fault_present;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rd_word;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int                num_errors = 0;
    int                checked = 0;
    int                n;
    logic [31:0]       set_in [4] = '{32'h000000C8, 32'h00010014, 32'h00000005, 32'h0000000A};
    logic [31:0]       set_out [4] = '{32'h00000064, 32'h00000064, 32'h0000000A, 32'h0000000A};

    // Clock, design and contactor
    always #50 clk = ~clk;
    cfm_top #(.CYCLE_CLKS(CYC)) u_cfm_top (
        .clk, .resetn, .monitored_in, .contactor_feedback_in(fb), .safety_out1, .safety_out2,
        .feedback_timeout_error, .fault_present, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    cfm_contactor u_cfm_contactor (.clk, .resetn, .coil(safety_out1), .welded, .delay_clks,
        .feedback(fb));

    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic timed_out();
        num_errors++;
        $display("Error at %0t: wait timed out", $time);
        complete_run();
    endtask

    // Register write: address and data offered together, each dropped when taken
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                             input logic [3:0] s);
        int k;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        s_axi_bready <= 1'b0;
        if (k == 40) timed_out();
        `CHECK(s_axi_bresp, RESP_OKAY)
    endtask

    // Register read
    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        int k;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (k == 40) timed_out();
        `CHECK(s_axi_rresp, RESP_OKAY)
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        axi_read(a, rd_word);
        `CHECK(rd_word, e)
    endtask

    // Wait for output 1 (sel 0) or the error output (sel 1) to reach a level
    task automatic wait_for(input int sel, input logic v, output int cnt);
        for (cnt = 0; cnt < 400; cnt++) begin
            @(posedge clk);
            if ((sel == 0 ? safety_out1 : feedback_timeout_error) === v) break;
        end
        if (cnt == 400) timed_out();
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        resetn = 1'b0;
        monitored_in = 1'b0;
        welded = 1'b0;
        delay_clks = 8'h02;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
        rd_chk(OFS_CTRL, 32'h0000000F);
        rd_chk(OFS_SETTING, 32'h0000001E);
        rd_chk(OFS_TIMER, 32'h00000000);
        rd_chk(OFS_STATUS, 32'h00000002);
        axi_write(OFS_STATUS, 32'h0000003F, 4'hF);
        axi_write(OFS_SETTING, 32'h00000050, 4'h0);
        rd_chk(OFS_STATUS, 32'h00000002);
        rd_chk(OFS_SETTING, 32'h0000001E);
        for (int i = 0; i < 4; i++) begin
            axi_write(OFS_SETTING, set_in[i], 4'hF);
            rd_chk(OFS_SETTING, set_out[i]);
        end
        // Healthy switching, prompt then slow contactor
        monitored_in <= 1'b1;
        wait_for(0, 1'b1, n);
        `CHECK(safety_out2, 1'b1)
        repeat (60) @(posedge clk);
        `CHECK({safety_out1, feedback_timeout_error}, 2'b10)
        delay_clks <= 8'h1E;
        monitored_in <= 1'b0;
        wait_for(0, 1'b0, n);
        `CHECK(safety_out2, 1'b0)
        repeat (60) @(posedge clk);
        `CHECK(feedback_timeout_error, 1'b0)
        rd_chk(OFS_STATUS, 32'h00000002);
        rd_chk(OFS_TIMER, 32'h00000007);
        // Welded contact: timeout after switching on
        welded <= 1'b1;
        monitored_in <= 1'b1;
        wait_for(0, 1'b1, n);
        wait_for(1, 1'b1, n);
        `CHECK(n + 1, 10 * CYC)
        `CHECK({safety_out1, safety_out2, fault_present}, 3'b001)
        repeat (40) @(posedge clk);
        `CHECK(safety_out1, 1'b0)
        axi_read(OFS_STATUS, rd_word);
        `CHECK(rd_word[4:0], 5'h13)
        axi_write(OFS_CTRL, 32'h00000009, 4'hF);
        repeat (2) @(posedge clk);
        `CHECK({feedback_timeout_error, fault_present}, 2'b01)
        welded <= 1'b0;
        monitored_in <= 1'b0;
        repeat (12) @(posedge clk);
        `CHECK({safety_out1, fault_present}, 2'b01)
        monitored_in <= 1'b1;
        wait_for(0, 1'b1, n);
        `CHECK({safety_out2, fault_present}, 2'b00)
        axi_write(OFS_CTRL, 32'h0000000F, 4'hF);
        repeat (2) @(posedge clk);
        `CHECK({safety_out2, feedback_timeout_error}, 2'b10)
        // Welded closed: timeout after switching off, then idle to run
        repeat (60) @(posedge clk);
        welded <= 1'b1;
        monitored_in <= 1'b0;
        wait_for(1, 1'b1, n);
        `CHECK(safety_out1, 1'b0)
        welded <= 1'b0;
        monitored_in <= 1'b1;
        repeat (40) @(posedge clk);
        `CHECK({safety_out1, feedback_timeout_error}, 2'b01)
        axi_write(OFS_CTRL, 32'h00000006, 4'hF);
        repeat (8) @(posedge clk);
        `CHECK({safety_out1, feedback_timeout_error, fault_present}, 3'b010)
        axi_write(OFS_CTRL, 32'h0000000F, 4'hF);
        wait_for(0, 1'b1, n);
        `CHECK({safety_out2, feedback_timeout_error, fault_present}, 3'b100)
        rd_chk(OFS_TIMER, 32'h00000000);
        complete_run();
    end
endmodule // cfm_top_test
